// [ums_defs.svh]
// constants for the serial and modem pin control block
// Contract
// - standard mode: transmit idles and resets high
// - infrared mode: pulses out, idle low
// - selectable receive inversion before infrared decoder
// - interrupt enable: drive interrupt, port2 low
// - interrupt disabled: interrupt tristate, port2 high
// - request output general or direction control
// - clear input readable, gates automatic transmit
// - terminal ready output under software control
// - set ready, carrier, ring readable inputs
`ifndef UMS_DEFS_SVH
`define UMS_DEFS_SVH
`define UMS_MCR_OP2_BIT    3
`define UMS_MCR_IR_BIT     6
`define UMS_EFR_ARTS_BIT   6
`define UMS_EFR_ACTS_BIT   7
`define UMS_IER_ARTS_BIT   6
`define UMS_IER_ACTS_BIT   7
`define UMS_DLD_HDX_BIT    6
`define UMS_FIFO_WIDTH     8
`define UMS_FIFO_DEPTH     16
`define UMS_BAUD_DIV       16'h0016
`define UMS_LAST_TICK      4'hf
`define UMS_STOP_BIT       4'h9
`define UMS_IR_PULSE_TICKS 4'h5
`define UMS_IDLE_HIGH      1'h1
`endif

// [ums_pkg.sv]
// types for the serial and modem pin control block
`default_nettype none
package ums_pkg;
  typedef enum logic [2:0] {
    UMS_IDLE  = 3'b001,
    UMS_SHIFT = 3'b010,
    UMS_DRAIN = 3'b100
  } ums_tx_state_t;
endpackage : ums_pkg
`default_nettype wire

// [ums_fifo.sv]
// small flip-flop fifo with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module ums_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // drain side
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [AW:0]      count, next_count;
  logic             push, pop;
  logic             next_in_ready, next_out_valid;

  always_comb begin
    push        = in_valid && in_ready;
    pop         = out_ready && out_valid;
    next_wr_ptr = push ? wr_ptr + AW'(1) : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + AW'(1) : rd_ptr;
    next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
    // flags taken from the next count so both ports come straight from flops
    next_in_ready  = (next_count != (AW+1)'(DEPTH));
    next_out_valid = (next_count != '0);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      wr_ptr    <= next_wr_ptr;
      rd_ptr    <= next_rd_ptr;
      count     <= next_count;
      in_ready  <= next_in_ready;
      out_valid <= next_out_valid;
    end
  end

  // storage has no reset; only written entries are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  assign out_data  = mem[rd_ptr];
endmodule : ums_fifo
`default_nettype wire

// [ums_chan.sv]
// one channel's serial and modem pin control, with transmit fifo and shifter
`timescale 1ns/10ps
`default_nettype none
`include "ums_defs.svh"
module ums_chan #(
  parameter int        WIDTH = `UMS_FIFO_WIDTH,
  parameter int        DEPTH = `UMS_FIFO_DEPTH,
  parameter logic [15:0] BAUD_DIV = `UMS_BAUD_DIV
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // software control
  input  wire logic [7:0]       modem_control_reg,
  input  wire logic [7:0]       enhanced_feature_reg,
  input  wire logic [7:0]       interrupt_enable_reg,
  input  wire logic [7:0]       divisor_extension_reg,
  input  wire logic             rx_invert,
  input  wire logic             rts_gp,
  input  wire logic             dtr_gp,
  input  wire logic             irq_level,
  // transmit data
  input  wire logic [WIDTH-1:0] tx_data,
  input  wire logic             tx_valid,
  output logic                  tx_ready,
  // pins
  output logic                  serial_out,
  input  wire logic             serial_in,
  output logic                  request_to_send_n,
  input  wire logic             clear_to_send_n,
  output logic                  terminal_ready_n,
  input  wire logic             set_ready_n,
  input  wire logic             carrier_detect_n,
  input  wire logic             ring_indicator_n,
  output logic                  output_port2_n,
  output logic                  interrupt_out,
  output logic                  interrupt_out_oe,
  // status back to software
  output logic [4:0]            modem_status,
  output logic                  rx_decoder_in,
  output logic                  tx_busy
);
  import ums_pkg::*;

  logic [4:0] sync1, sync2;
  logic [WIDTH-1:0] f_data;
  logic f_valid, f_ready;
  ums_tx_state_t state, next_state;
  logic [15:0] div_cnt, next_div_cnt;
  logic [3:0] tick_cnt, next_tick_cnt, bit_cnt, next_bit_cnt;
  logic [WIDTH+1:0] shreg, next_shreg;
  logic tick, ir_mode, cts_gate, line_bit;
  logic next_serial_out, next_rts_n, next_dtr_n, next_op2_n, next_int, next_int_oe;
  logic [4:0] next_status;
  logic next_dec_in, next_busy;

  ums_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
    .clk      (clk),
    .reset_n  (reset_n),
    .in_data  (tx_data),
    .in_valid (tx_valid),
    .in_ready (tx_ready),
    .out_data (f_data),
    .out_valid(f_valid),
    .out_ready(f_ready)
  );

  // first stage feeds the second only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1 <= 5'h1f;
      sync2 <= 5'h1f;
    end else begin
      sync1 <= {serial_in, clear_to_send_n, set_ready_n, carrier_detect_n, ring_indicator_n};
      sync2 <= sync1;
    end
  end

  always_comb begin
    ir_mode  = modem_control_reg[`UMS_MCR_IR_BIT];
    // auto clear-to-send holds off a new character while the far end is not ready
    cts_gate = enhanced_feature_reg[`UMS_EFR_ACTS_BIT] && interrupt_enable_reg[`UMS_IER_ACTS_BIT]
               && sync2[3];
    tick          = (div_cnt == BAUD_DIV);
    next_div_cnt  = tick ? 16'h0000 : div_cnt + 16'h0001;
    next_state    = state;
    next_tick_cnt = tick_cnt;
    next_bit_cnt  = bit_cnt;
    next_shreg    = shreg;
    f_ready       = 1'b0;
    unique case (state)
      UMS_IDLE: begin
        if (f_valid && !cts_gate) begin
          f_ready       = 1'b1;
          next_shreg    = {1'b1, f_data, 1'b0};
          next_bit_cnt  = 4'h0;
          next_tick_cnt = 4'h0;
          next_state    = UMS_SHIFT;
        end
      end
      UMS_SHIFT: begin
        if (tick) begin
          next_tick_cnt = tick_cnt + 4'h1;
          if (tick_cnt == `UMS_LAST_TICK) begin
            next_shreg   = {1'b1, shreg[WIDTH+1:1]};
            next_bit_cnt = bit_cnt + 4'h1;
            if (bit_cnt == `UMS_STOP_BIT) begin
              next_state = UMS_DRAIN;
            end
          end
        end
      end
      UMS_DRAIN: begin
        next_state = UMS_IDLE;
      end
    endcase
    line_bit = (state == UMS_SHIFT) ? shreg[0] : `UMS_IDLE_HIGH;
    // infrared: short high pulse for each zero bit, low otherwise
    if (ir_mode) begin
      next_serial_out = (state == UMS_SHIFT) && !shreg[0] && (tick_cnt < `UMS_IR_PULSE_TICKS);
    end else begin
      next_serial_out = line_bit;
    end
    // half duplex: drive active while the fifo holds data or a character is on the line
    if (divisor_extension_reg[`UMS_DLD_HDX_BIT]) begin
      next_rts_n = !(state != UMS_IDLE || f_valid);
    end else begin
      next_rts_n = !rts_gp;
    end
    next_dtr_n  = !dtr_gp;
    next_int_oe = modem_control_reg[`UMS_MCR_OP2_BIT];
    next_op2_n  = !modem_control_reg[`UMS_MCR_OP2_BIT];
    next_int    = irq_level && modem_control_reg[`UMS_MCR_OP2_BIT];
    next_status = sync2;
    next_dec_in = sync2[4] ^ rx_invert;
    next_busy   = (state != UMS_IDLE);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state            <= UMS_IDLE;
      div_cnt          <= 16'h0000;
      tick_cnt         <= 4'h0;
      bit_cnt          <= 4'h0;
      shreg            <= '1;
      serial_out       <= 1'b1;
      request_to_send_n <= 1'b1;
      terminal_ready_n <= 1'b1;
      output_port2_n   <= 1'b1;
      interrupt_out    <= 1'b0;
      interrupt_out_oe <= 1'b0;
      modem_status     <= 5'h1f;
      rx_decoder_in    <= 1'b0;
      tx_busy          <= 1'b0;
    end else begin
      state            <= next_state;
      div_cnt          <= next_div_cnt;
      tick_cnt         <= next_tick_cnt;
      bit_cnt          <= next_bit_cnt;
      shreg            <= next_shreg;
      serial_out       <= next_serial_out;
      request_to_send_n <= next_rts_n;
      terminal_ready_n <= next_dtr_n;
      output_port2_n   <= next_op2_n;
      interrupt_out    <= next_int;
      interrupt_out_oe <= next_int_oe;
      modem_status     <= next_status;
      rx_decoder_in    <= next_dec_in;
      tx_busy          <= next_busy;
    end
  end
endmodule : ums_chan
`default_nettype wire

// [ums_chan_props.sv]
// concurrent checks on one channel of the pin control block
`timescale 1ns/10ps
`default_nettype none
module ums_chan_props (
  // clock and reset
  input wire logic       clk,
  input wire logic       reset_n,
  // software control
  input wire logic       rts_gp,
  input wire logic       dtr_gp,
  input wire logic       irq_level,
  input wire logic [7:0] modem_control_reg,
  input wire logic [7:0] enhanced_feature_reg,
  input wire logic [7:0] interrupt_enable_reg,
  input wire logic [7:0] divisor_extension_reg,
  // pins and transmit busy status
  input wire logic       serial_out,
  input wire logic       request_to_send_n,
  input wire logic       clear_to_send_n,
  input wire logic       terminal_ready_n,
  input wire logic       output_port2_n,
  input wire logic       interrupt_out,
  input wire logic       interrupt_out_oe,
  input wire logic       tx_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic auto_cts;
  assign auto_cts = enhanced_feature_reg[7] & interrupt_enable_reg[7];
  // idle only once the mode bit has settled, since the pin is registered
  sequence s_idle;
    !tx_busy && !$past(tx_busy) && $stable(modem_control_reg[6]);
  endsequence
  AST_OP2_ON: assert property (modem_control_reg[3] |=> !output_port2_n && interrupt_out_oe)
    else $error("port2 or drive wrong with enable set");
  AST_OP2_OFF: assert property (!modem_control_reg[3] |=> output_port2_n && !interrupt_out_oe)
    else $error("port2 or drive wrong with enable clear");
  AST_INT_PASS: assert property (modem_control_reg[3] |=> interrupt_out == $past(irq_level))
    else $error("interrupt level not passed");
  AST_IDLE_STD: assert property (s_idle ##0 !modem_control_reg[6] |-> serial_out)
    else $error("standard idle not high");
  AST_IDLE_IR: assert property (s_idle ##0 modem_control_reg[6] |-> !serial_out)
    else $error("infrared idle not low");
  AST_RTS_GP: assert property (!divisor_extension_reg[6] |=> request_to_send_n != $past(rts_gp))
    else $error("request output not following software");
  AST_DTR_GP: assert property ($changed(dtr_gp) |=> terminal_ready_n != $past(dtr_gp))
    else $error("terminal ready not following software");
  // five cycles covers the two sync stages and the load decision
  AST_CTS_GATE: assert property ((auto_cts && clear_to_send_n) [*5] ##0 !tx_busy |=> !tx_busy)
    else $error("character started while clear to send high");
  cover property (modem_control_reg[3] && irq_level);
  cover property ($rose(tx_busy) && modem_control_reg[6]);
  cover property (auto_cts && clear_to_send_n && !tx_busy);
endmodule : ums_chan_props
bind ums_chan ums_chan_props ums_chan_props_inst (.clk, .reset_n, .rts_gp, .dtr_gp, .irq_level, .modem_control_reg,
  .enhanced_feature_reg, .interrupt_enable_reg, .divisor_extension_reg, .serial_out, .request_to_send_n,
  .clear_to_send_n, .terminal_ready_n, .output_port2_n, .interrupt_out, .interrupt_out_oe, .tx_busy);
`default_nettype wire

// [ums_far_end.sv]
// far-end line and modem model driving the receive and handshake pins
`timescale 1ns/10ps
`default_nettype none
module ums_far_end (
  // clock and wanted levels {rx, cts, dsr, cd, ri}
  input  wire logic       clk,
  input  wire logic [4:0] lvl,
  // pins toward the channel
  output logic            serial_in,
  output logic            clear_to_send_n,
  output logic            set_ready_n,
  output logic            carrier_detect_n,
  output logic            ring_indicator_n
);
  // moves just after an edge like a real driver; bench asks all high when idle
  always_ff @(posedge clk)
    {serial_in, clear_to_send_n, set_ready_n, carrier_detect_n, ring_indicator_n} <= lvl;
endmodule : ums_far_end
`default_nettype wire

// [tb_ums_chan.sv]
// self-checking testbench for one pin control channel
`timescale 1ns/10ps
`default_nettype none
module tb_ums_chan;
  logic        clk = 1'h0, reset_n = 1'h0, rx_invert = 1'h0, rts_gp = 1'h0, dtr_gp = 1'h0, irq_level = 1'h0;
  logic        tx_valid = 1'h0, tx_ready, serial_out, serial_in, request_to_send_n, clear_to_send_n, set_ready_n;
  logic        terminal_ready_n, carrier_detect_n, ring_indicator_n, output_port2_n, interrupt_out;
  logic        interrupt_out_oe, rx_decoder_in, tx_busy;
  logic [7:0]  modem_control_reg = 8'h00, enhanced_feature_reg = 8'h00, interrupt_enable_reg = 8'h00;
  logic [7:0]  divisor_extension_reg = 8'h00, tx_data = 8'h00;
  logic [4:0]  lvl = 5'h1f, modem_status;
  // {port2 enable, rts, dtr, irq, far levels, port2_n, oe, int, rts_n, dtr_n}
  logic [13:0] rows [4] = '{14'h37ed, 14'h0eb2, 14'h214b, 14'h1810};
  int          n_fail = 0, checked = 0, k;
  always #12.5 clk = ~clk;
  ums_chan #(.BAUD_DIV(16'h0000)) ums_chan_inst (.clk, .reset_n, .modem_control_reg, .enhanced_feature_reg,
    .interrupt_enable_reg, .divisor_extension_reg, .rx_invert, .rts_gp, .dtr_gp, .irq_level, .tx_data, .tx_valid,
    .tx_ready, .serial_out, .serial_in, .request_to_send_n, .clear_to_send_n, .terminal_ready_n, .set_ready_n,
    .carrier_detect_n, .ring_indicator_n, .output_port2_n, .interrupt_out, .interrupt_out_oe, .modem_status,
    .rx_decoder_in, .tx_busy);
  ums_far_end ums_far_end_inst (.clk, .lvl, .serial_in, .clear_to_send_n, .set_ready_n, .carrier_detect_n,
    .ring_indicator_n);
  task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // bit period is 16 clocks with the divider at zero; look early and mid-bit
  task send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    tx_data = d;
    tx_valid = 1'h1;
    @(negedge clk);
    tx_valid = 1'h0;
    k = 0;
    while (!tx_busy && k < 50) begin
      @(negedge clk);
      k++;
    end
    chk("tx_start", 8'h01, 8'(tx_busy));
    for (int j = 0; j < 10; j++) begin
      @(negedge clk);
      chk("tx_early", modem_control_reg[6] ? !f[j] : f[j], serial_out);
      repeat (7) @(negedge clk);
      chk("tx_mid", modem_control_reg[6] ? 1'b0 : f[j], serial_out);
      repeat (8) @(negedge clk);
    end
  endtask : send
  task complete_run;
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  // port2 is never used as a general output and auto request flow stays off
  initial begin
    repeat (4) @(negedge clk);
    chk("rst_pins", 8'hf1, {serial_out, request_to_send_n, terminal_ready_n, output_port2_n, interrupt_out,
      interrupt_out_oe, tx_busy, tx_ready});
    chk("rst_stat", 8'h1f, {2'b00, rx_decoder_in, modem_status});
    reset_n = 1'h1;
    foreach (rows[i]) begin
      {modem_control_reg[3], rts_gp, dtr_gp, irq_level, lvl} = rows[i][13:5];
      repeat (5) @(negedge clk);
      chk("ctl", rows[i][4:0], {output_port2_n, interrupt_out_oe, interrupt_out & interrupt_out_oe,
        request_to_send_n, terminal_ready_n});
      chk("status", rows[i][9:5], modem_status);
    end
    send(8'h5a);
    modem_control_reg[6] = 1'h1;
    send(8'h3c);
    modem_control_reg[6] = 1'h0;
    lvl = 5'h1f;
    // both line levels under both inversion settings
    for (int j = 0; j < 4; j++) begin
      {lvl[4], rx_invert} = 2'(j);
      repeat (5) @(negedge clk);
      chk("dec_in", 8'(j[1] ^ j[0]), 8'(rx_decoder_in));
    end
    // hold transmit with clear to send off, fill the fifo, then let it drain
    {enhanced_feature_reg[7], interrupt_enable_reg[7], divisor_extension_reg[6], rts_gp} = 4'he;
    repeat (5) @(negedge clk);
    k = 0;
    tx_valid = 1'h1;
    while (tx_ready && k < 40) begin
      tx_data = 8'(k);
      @(negedge clk);
      k++;
    end
    tx_valid = 1'h0;
    chk("fill", 8'h10, 8'(k));
    chk("held", 8'h00, {tx_busy, request_to_send_n});
    lvl[3] = 1'h0;
    repeat (100) @(negedge clk);
    chk("hdx", 8'h02, {tx_busy, request_to_send_n});
    k = 0;
    while (request_to_send_n !== 1'b1 && k < 4000) begin
      @(negedge clk);
      k++;
    end
    chk("drain", 8'h06, {k < 4000, tx_ready, tx_busy});
    // reset in mid-character must drop the line back to idle high
    tx_data = 8'h00;
    tx_valid = 1'h1;
    @(negedge clk);
    tx_valid = 1'h0;
    repeat (4) @(negedge clk);
    chk("mid_char", 8'h02, {tx_busy, serial_out});
    reset_n = 1'h0;
    repeat (4) @(negedge clk);
    chk("mid_rst", 8'h07, {tx_busy, serial_out, request_to_send_n, tx_ready});
    reset_n = 1'h1;
    repeat (2) @(negedge clk);
    chk("post_rst", 8'h07, {tx_busy, serial_out, request_to_send_n, tx_ready});
    complete_run();
  end
  initial begin
    #250000;
    n_fail++;
    complete_run();
  end
endmodule : tb_ums_chan
`default_nettype wire
